/* File: sps_sequencer.v */
// segment position sequencer: segment table, register port and the segment stepping machine
// assumes planner signals come from logic on clk_i; software drives a one-cycle strobe bus
`timescale 1ns/1ns
`default_nettype none
`include "sps_defines.vh"
module sps_sequencer #(
    parameter SEG_AW     = 4,
    parameter POS_W      = 32,
    parameter JUMP_LIMIT = `SPS_JUMP_LIMIT
) (
    // clock and reset
    input  wire                   clk_i,
    input  wire                   rstn_i,
    // register port
    input  wire [`SPS_ADDR_W-1:0] addr_i,
    input  wire [31:0]            wdata_i,
    input  wire                   wr_i,
    input  wire                   rd_i,
    output wire [31:0]            rdata_o,
    // planner feedback
    input  wire [POS_W-1:0]       feedback_position_i,
    input  wire [POS_W-1:0]       remaining_distance_i,
    input  wire                   seg_done_i,
    input  wire                   speed_reached_i,
    // planner command
    output wire                   cmd_valid_o,
    output reg                    cmd_is_speed_o,
    output reg                    cmd_interrupt_o,
    output reg  [POS_W-1:0]       target_position_o,
    output reg  [31:0]            speed_value_o,
    output reg  [15:0]            param_select_o,
    // status
    output wire                   busy_o,
    output wire [SEG_AW-1:0]      seg_index_o
);
    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_FETCH  = 3'h1;
    localparam [2:0] ST_DECIDE = 3'h2;
    localparam [2:0] ST_RUN    = 3'h3;
    localparam [2:0] ST_HOLD   = 3'h4;

    // target position for a position segment
    function [POS_W-1:0] sps_target;
        input [1:0]       ptype;
        input [POS_W-1:0] value;
        input [POS_W-1:0] prev;
        input [POS_W-1:0] fdb;
        begin
            case (ptype)
                `SPS_PT_INC: sps_target = prev + value;
                `SPS_PT_REL: sps_target = fdb + value;
                default:     sps_target = value;
            endcase
        end
    endfunction

    // state
    reg [2:0]        state_r;
    reg [SEG_AW-1:0] seg_r;
    reg [SEG_AW-1:0] start_seg_r;
    reg [1:0]        cur_mode_r;
    reg              cur_chain_r;
    reg              running_r;
    reg              jump_err_r;
    reg [5:0]        jump_cnt_r;
    reg [POS_W-1:0]  prev_cmd_r;
    reg [31:0]       pend_cw_r;
    reg [31:0]       pend_val_r;
    reg              cmd_valid_r;

    // bus side
    reg                   rd_tbl_cw_r;
    reg                   rd_tbl_val_r;
    reg [31:0]            rd_reg_r;

    wire [31:0] bus_cw;
    wire [31:0] bus_val;
    wire [31:0] seq_cw;
    wire [31:0] seq_val;

    // bus decode
    wire [3:0] tbl_sel   = addr_i[`SPS_ADDR_W-1:`SPS_ADDR_W-4];
    wire       in_word   = (addr_i[1:0] == 2'h0) && (addr_i[7:SEG_AW+2] == {(6-SEG_AW){1'b0}});
    wire       wr_cw     = wr_i && (tbl_sel == `SPS_TBL_CW) && in_word;
    wire       wr_val    = wr_i && (tbl_sel == `SPS_TBL_VAL) && in_word;
    wire       wr_ctrl   = wr_i && (addr_i == `SPS_OFF_CTRL);
    wire       sw_start  = wr_ctrl && wdata_i[`SPS_CTRL_START];
    wire       sw_stop   = wr_ctrl && wdata_i[`SPS_CTRL_STOP];
    wire       sw_adv    = wr_ctrl && wdata_i[`SPS_CTRL_ADVANCE];
    wire       fetch_en  = (state_r == ST_FETCH);

    // fetched control word fields, low half only
    wire [15:0] seq_low   = seq_cw[`SPS_CW_HALF-1:0];
    wire [1:0]  f_mode    = seq_low[`SPS_F_MODE_HI:`SPS_F_MODE_LO];
    wire [1:0]  f_ptype   = seq_low[`SPS_F_PTYPE_HI:`SPS_F_PTYPE_LO];
    wire        f_intr    = seq_low[`SPS_F_INTR];
    wire [1:0]  p_ptype   = pend_cw_r[`SPS_F_PTYPE_HI:`SPS_F_PTYPE_LO];
    wire        prev_pos  = running_r && (cur_mode_r != `SPS_MODE_SPEED);
    wire [POS_W-1:0] carry = prev_pos ? remaining_distance_i : {POS_W{1'b0}};

    // control word table
    sps_seg_mem #(.DW(32), .AW(SEG_AW)) u_cw_mem (
        .clk_i     (clk_i),
        .rstn_i    (rstn_i),
        .wr_en_i   (wr_cw),
        .wr_addr_i (addr_i[SEG_AW+1:2]),
        .wr_data_i (wdata_i),
        .ra_en_i   (rd_i),
        .ra_addr_i (addr_i[SEG_AW+1:2]),
        .ra_data_o (bus_cw),
        .rb_en_i   (fetch_en),
        .rb_addr_i (seg_r),
        .rb_data_o (seq_cw)
    );

    // command value table
    sps_seg_mem #(.DW(32), .AW(SEG_AW)) u_val_mem (
        .clk_i     (clk_i),
        .rstn_i    (rstn_i),
        .wr_en_i   (wr_val),
        .wr_addr_i (addr_i[SEG_AW+1:2]),
        .wr_data_i (wdata_i),
        .ra_en_i   (rd_i),
        .ra_addr_i (addr_i[SEG_AW+1:2]),
        .ra_data_o (bus_val),
        .rb_en_i   (fetch_en),
        .rb_addr_i (seg_r),
        .rb_data_o (seq_val)
    );

    // start segment holds in the control register
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            start_seg_r <= {SEG_AW{1'b0}};
        end else if (wr_ctrl) begin
            start_seg_r <= wdata_i[`SPS_CTRL_SEG_LO+SEG_AW-1:`SPS_CTRL_SEG_LO];
        end
    end

    // register read, data in the following cycle
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_tbl_cw_r  <= 1'b0;
            rd_tbl_val_r <= 1'b0;
            rd_reg_r     <= 32'h0000_0000;
        end else if (rd_i) begin
            rd_tbl_cw_r  <= (tbl_sel == `SPS_TBL_CW) && in_word;
            rd_tbl_val_r <= (tbl_sel == `SPS_TBL_VAL) && in_word;
            case (addr_i)
                `SPS_OFF_CTRL:    rd_reg_r <= {{(24-SEG_AW){1'b0}}, start_seg_r, 8'h00};
                `SPS_OFF_STATUS:  rd_reg_r <= {14'h0000, cur_mode_r, {(8-SEG_AW){1'b0}}, seg_r,
                                               3'h0, jump_err_r, 1'b0, state_r};
                `SPS_OFF_TARGET:  rd_reg_r <= target_position_o;
                `SPS_OFF_PREVCMD: rd_reg_r <= prev_cmd_r;
                `SPS_OFF_SPEED:   rd_reg_r <= speed_value_o;
                default:          rd_reg_r <= 32'h0000_0000;
            endcase
        end
    end

    // table reads come straight from the memory output register
    assign rdata_o = rd_tbl_cw_r ? bus_cw : (rd_tbl_val_r ? bus_val : rd_reg_r);

    // segment stepping machine
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r           <= ST_IDLE;
            seg_r             <= {SEG_AW{1'b0}};
            cur_mode_r        <= `SPS_MODE_SINGLE;
            cur_chain_r       <= 1'b0;
            running_r         <= 1'b0;
            jump_err_r        <= 1'b0;
            jump_cnt_r        <= 6'h00;
            prev_cmd_r        <= {POS_W{1'b0}};
            pend_cw_r         <= 32'h0000_0000;
            pend_val_r        <= 32'h0000_0000;
            cmd_valid_r       <= 1'b0;
            cmd_is_speed_o    <= 1'b0;
            cmd_interrupt_o   <= 1'b0;
            target_position_o <= {POS_W{1'b0}};
            speed_value_o     <= 32'h0000_0000;
            param_select_o    <= 16'h0000;
        end else begin
            cmd_valid_r     <= 1'b0;
            cmd_interrupt_o <= 1'b0;
            if (sw_stop) begin
                state_r   <= ST_IDLE;
                running_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        if (sw_start) begin
                            seg_r      <= wdata_i[`SPS_CTRL_SEG_LO+SEG_AW-1:`SPS_CTRL_SEG_LO];
                            jump_err_r <= 1'b0;
                            jump_cnt_r <= 6'h00;
                            state_r    <= ST_FETCH;
                        end
                    end
                    ST_FETCH: begin
                        state_r <= ST_DECIDE;
                    end
                    ST_DECIDE: begin
                        if (f_mode == `SPS_MODE_JUMP) begin
                            if (jump_cnt_r == JUMP_LIMIT[5:0]) begin
                                jump_err_r <= 1'b1;
                                running_r  <= 1'b0;
                                state_r    <= ST_IDLE;
                            end else begin
                                seg_r      <= seq_val[SEG_AW-1:0];
                                jump_cnt_r <= jump_cnt_r + 6'h01;
                                state_r    <= ST_FETCH;
                            end
                        end else if (!running_r || f_intr || (cur_mode_r == `SPS_MODE_SPEED)) begin
                            // intr judged from the segment now triggered
                            jump_cnt_r     <= 6'h00;
                            cmd_valid_r    <= 1'b1;
                            cmd_interrupt_o <= running_r && f_intr;
                            running_r      <= 1'b1;
                            cur_mode_r     <= f_mode;
                            cur_chain_r    <= (f_ptype == `SPS_PT_INC);
                            param_select_o <= seq_cw[31:16];
                            state_r        <= ST_RUN;
                            if (f_mode == `SPS_MODE_SPEED) begin
                                cmd_is_speed_o <= 1'b1;
                                speed_value_o  <= seq_val;
                            end else begin
                                cmd_is_speed_o    <= 1'b0;
                                target_position_o <= sps_target(f_ptype, seq_val, prev_cmd_r,
                                                     feedback_position_i) + (f_intr ? carry : {POS_W{1'b0}});
                                prev_cmd_r        <= sps_target(f_ptype, seq_val, prev_cmd_r,
                                                     feedback_position_i) + (f_intr ? carry : {POS_W{1'b0}});
                            end
                        end else begin
                            pend_cw_r  <= seq_cw;
                            pend_val_r <= seq_val;
                            jump_cnt_r <= 6'h00;
                            state_r    <= ST_HOLD;
                        end
                    end
                    ST_RUN: begin
                        case (cur_mode_r)
                            `SPS_MODE_SINGLE: begin
                                if (seg_done_i) begin
                                    running_r <= 1'b0;
                                    state_r   <= ST_IDLE;
                                end
                            end
                            `SPS_MODE_MULTI: begin
                                seg_r   <= seg_r + {{(SEG_AW-1){1'b0}}, 1'b1};
                                state_r <= ST_FETCH;
                            end
                            default: begin
                                if ((cur_chain_r && speed_reached_i) || sw_adv) begin
                                    seg_r   <= seg_r + {{(SEG_AW-1){1'b0}}, 1'b1};
                                    state_r <= ST_FETCH;
                                end
                            end
                        endcase
                    end
                    ST_HOLD: begin
                        if (seg_done_i) begin
                            cmd_valid_r    <= 1'b1;
                            cur_mode_r     <= pend_cw_r[`SPS_F_MODE_HI:`SPS_F_MODE_LO];
                            cur_chain_r    <= (p_ptype == `SPS_PT_INC);
                            param_select_o <= pend_cw_r[31:16];
                            state_r        <= ST_RUN;
                            if (pend_cw_r[`SPS_F_MODE_HI:`SPS_F_MODE_LO] == `SPS_MODE_SPEED) begin
                                cmd_is_speed_o <= 1'b1;
                                speed_value_o  <= pend_val_r;
                            end else begin
                                cmd_is_speed_o    <= 1'b0;
                                target_position_o <= sps_target(p_ptype, pend_val_r, prev_cmd_r,
                                                                feedback_position_i);
                                prev_cmd_r        <= sps_target(p_ptype, pend_val_r, prev_cmd_r,
                                                                feedback_position_i);
                            end
                        end
                    end
                    default: begin
                        state_r   <= ST_IDLE;
                        running_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // planner and status outputs
    assign cmd_valid_o = cmd_valid_r;
    assign busy_o      = (state_r != ST_IDLE);
    assign seg_index_o = seg_r;
endmodule // sps_sequencer
`default_nettype wire

/* File: sps_defines.vh */
// constants for the segment position sequencer: register map, control word fields, mode codes
// assumes plain Verilog-2005 includers; holds definitions only
// Operation
// - single segment stops after finishing itself
// - multi segment starts following segment on completion
// - speed segment holds speed until next starts
// - jump goes straight to the named segment
// - type 0: target equals commanded value
// - type 1: previous command plus increment
// - type 2: feedback position plus relative value
// - speed: type 1 chains on speed reached
// - interrupt bit decoded in every mode but jump, where it is ignored
// - interrupt enabled: switch at once, finished or not
// - interrupted remainder added to next target
// - interrupt disabled: wait for full completion first
// - later segment's interrupt bit governs, judged at trigger
// - low control word half holds planning fields
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH

// register bus geometry and map (byte addresses)
`define SPS_ADDR_W        12
`define SPS_OFF_CTRL      12'h000
`define SPS_OFF_STATUS    12'h004
`define SPS_OFF_TARGET    12'h008
`define SPS_OFF_PREVCMD   12'h00C
`define SPS_OFF_SPEED     12'h010
`define SPS_TBL_CW        4'h1
`define SPS_TBL_VAL       4'h2

// control register bits
`define SPS_CTRL_START    0
`define SPS_CTRL_STOP     1
`define SPS_CTRL_ADVANCE  2
`define SPS_CTRL_SEG_LO   8
`define SPS_CTRL_RESET    32'h0000_0000

// segment control word fields, all in the low half
`define SPS_F_MODE_LO     0
`define SPS_F_MODE_HI     1
`define SPS_F_PTYPE_LO    2
`define SPS_F_PTYPE_HI    3
`define SPS_F_INTR        4
`define SPS_CW_HALF       16

// operating modes
`define SPS_MODE_SINGLE   2'h0
`define SPS_MODE_MULTI    2'h1
`define SPS_MODE_SPEED    2'h2
`define SPS_MODE_JUMP     2'h3

// position types
`define SPS_PT_ABS        2'h0
`define SPS_PT_INC        2'h1
`define SPS_PT_REL        2'h2

// longest run of jumps before the sequencer gives up
`define SPS_JUMP_LIMIT    16

`endif

/* File: sps_seg_mem.v */
// segment table memory: one write port, two read ports with registered data
// assumes writer and readers share clk_i
`timescale 1ns/1ns
`default_nettype none
module sps_seg_mem #(
    parameter DW = 32,
    parameter AW = 4
) (
    // clock and reset
    input  wire          clk_i,
    input  wire          rstn_i,
    // write port
    input  wire          wr_en_i,
    input  wire [AW-1:0] wr_addr_i,
    input  wire [DW-1:0] wr_data_i,
    // read port a
    input  wire          ra_en_i,
    input  wire [AW-1:0] ra_addr_i,
    output reg  [DW-1:0] ra_data_o,
    // read port b
    input  wire          rb_en_i,
    input  wire [AW-1:0] rb_addr_i,
    output reg  [DW-1:0] rb_data_o
);
    reg [DW-1:0] mem_r [0:(1<<AW)-1];

    // array write, no reset so it maps onto ram
    always @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
    end

    // registered read data on both ports
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ra_data_o <= {DW{1'b0}};
            rb_data_o <= {DW{1'b0}};
        end else begin
            if (ra_en_i) begin
                ra_data_o <= mem_r[ra_addr_i];
            end
            if (rb_en_i) begin
                rb_data_o <= mem_r[rb_addr_i];
            end
        end
    end
endmodule // sps_seg_mem
`default_nettype wire

/* File: sps_sequencer_asserts.sv */
// port checker for the segment sequencer
// assumes one clock domain; bound to the top module below
`timescale 1ns/1ns
`default_nettype none
module sps_sequencer_asserts #(
    parameter POS_W = 32
) (
    // clock and reset
    input wire logic             clk_i,
    input wire logic             rstn_i,
    // register port
    input wire logic [11:0]      addr_i,
    input wire logic [31:0]      wdata_i,
    input wire logic             wr_i,
    input wire logic             rd_i,
    input wire logic [31:0]      rdata_o,
    // planner side
    input wire logic             speed_reached_i,
    input wire logic             cmd_valid_o,
    input wire logic             cmd_is_speed_o,
    input wire logic             cmd_interrupt_o,
    input wire logic [POS_W-1:0] target_position_o,
    input wire logic [31:0]      speed_value_o,
    input wire logic             busy_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    // start written while idle
    sequence start_wr;
        wr_i && addr_i == 12'h000 && wdata_i[0] && !wdata_i[1] && !busy_o;
    endsequence
    // command from a running sequencer
    sequence cmd_out;
        cmd_valid_o && busy_o;
    endsequence
    // speed command running with no trigger
    sequence speed_quiet;
        (cmd_is_speed_o && !speed_reached_i && !wr_i) [*8];
    endsequence
    AST_START_LAT: assert property (start_wr |-> ##[3:40] cmd_out)
        else $error("no command after start");
    AST_CMD_PULSE: assert property (cmd_valid_o |=> !cmd_valid_o)
        else $error("command pulse too long");
    AST_INTR_PAIR: assert property (cmd_interrupt_o |-> cmd_valid_o && $past(busy_o))
        else $error("interrupt without a running segment");
    AST_IDLE_QUIET: assert property (!busy_o |-> !cmd_valid_o)
        else $error("command while idle");
    AST_TARGET_CAUSE: assert property ($changed(target_position_o) |-> cmd_valid_o && !cmd_is_speed_o)
        else $error("target moved without position command");
    AST_SPEED_HOLD: assert property ($changed(speed_value_o) |-> cmd_valid_o && cmd_is_speed_o)
        else $error("speed moved without speed command");
    AST_UNMAPPED: assert property (rd_i && addr_i == 12'hFFC |=> rdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_CHAIN_WAIT: assert property (speed_quiet |=> !cmd_valid_o)
        else $error("speed segment left without trigger");
endmodule // sps_sequencer_asserts
bind sps_sequencer sps_sequencer_asserts #(.POS_W(POS_W)) u_sps_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .speed_reached_i(speed_reached_i), .cmd_valid_o(cmd_valid_o),
    .cmd_is_speed_o(cmd_is_speed_o), .cmd_interrupt_o(cmd_interrupt_o),
    .target_position_o(target_position_o), .speed_value_o(speed_value_o), .busy_o(busy_o));
`default_nettype wire

/* File: sps_planner_model.sv */
// planner model: completes position commands and reaches speed after a delay
// assumes commands arrive as one-cycle pulses on clk_i
`timescale 1ns/1ns
`default_nettype none
module sps_planner_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // command and settings
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_is_speed_i,
    input  wire logic [7:0]  dly_i,
    input  wire logic [31:0] fdb_i,
    input  wire logic [31:0] rem_i,
    // feedback
    output var  logic        seg_done_o,
    output var  logic        speed_reached_o,
    output wire logic [31:0] feedback_position_o,
    output wire logic [31:0] remaining_distance_o
);
    logic [7:0] cnt_r;
    logic       run_r;
    logic       spd_r;
    // position levels are held steady by the bench
    assign feedback_position_o  = fdb_i;
    assign remaining_distance_o = rem_i;
    // count down, then pulse done or hold speed reached until next command
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r           <= 8'h00;
            run_r           <= 1'b0;
            spd_r           <= 1'b0;
            seg_done_o      <= 1'b0;
            speed_reached_o <= 1'b0;
        end else if (cmd_valid_i) begin
            cnt_r           <= dly_i;
            run_r           <= 1'b1;
            spd_r           <= cmd_is_speed_i;
            seg_done_o      <= 1'b0;
            speed_reached_o <= 1'b0;
        end else if (run_r && cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end else if (run_r) begin
            run_r           <= spd_r;
            seg_done_o      <= !spd_r;
            speed_reached_o <= spd_r;
        end else begin
            seg_done_o <= 1'b0;
        end
    end
endmodule // sps_planner_model
`default_nettype wire

/* File: tb_top.sv */
// testbench for the segment sequencer with a planner model
// assumes a 10 MHz clock and the strobe register bus
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam logic [31:0] MD = 32'h0032_2114; // mode, two bits per segment
    localparam logic [31:0] PT = 32'h0000_1490; // type or chain, two bits per segment
    localparam logic [15:0] IE = 16'h0022;      // interrupt enable per segment
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [31:0] fdb_v = 32'h0000_0000;
    logic [31:0] rem_v = 32'h0000_0000;
    logic [31:0] seed = 32'h40936D97;
    logic [31:0] val [16];
    logic [31:0] cwv [16];
    wire  [31:0] rdata_o, fdb, rem, target_position_o, speed_value_o;
    wire  [15:0] param_select_o;
    wire         done, reached, cmd_valid_o, cmd_is_speed_o, cmd_interrupt_o, busy_o;
    wire  [3:0]  seg_idx;
    int          fails = 0;
    int          checked = 0;
    int          cyc = 0;
    int          n;
    sps_sequencer uut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .feedback_position_i(fdb), .remaining_distance_i(rem),
        .seg_done_i(done), .speed_reached_i(reached), .cmd_valid_o(cmd_valid_o),
        .cmd_is_speed_o(cmd_is_speed_o), .cmd_interrupt_o(cmd_interrupt_o),
        .target_position_o(target_position_o), .speed_value_o(speed_value_o),
        .param_select_o(param_select_o), .busy_o(busy_o), .seg_index_o(seg_idx));
    sps_planner_model u_plan (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_o),
        .cmd_is_speed_i(cmd_is_speed_o), .dly_i(8'h0A), .fdb_i(fdb_v), .rem_i(rem_v),
        .seg_done_o(done), .speed_reached_o(reached), .feedback_position_o(fdb),
        .remaining_distance_o(rem));
    // clock and hang guard
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails = fails + 1;
            final_report;
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected target of segment k after command p with remainder r
    function automatic logic [31:0] tgt(input int k, input logic [31:0] p, input logic [31:0] r);
        logic [1:0] t;
        t = PT[2*k +: 2];
        tgt = (t == 2'h0) ? val[k] : (t == 2'h1) ? p + val[k] : fdb_v + val[k];
        tgt = tgt + r;
    endfunction
    task automatic final_report;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        @(negedge clk_i);
        chk(nm, rdata_o, e);
    endtask
    task automatic wait_cmd(input int lim, output int k);
        k = 0;
        @(negedge clk_i);
        while (cmd_valid_o !== 1'b1 && k < lim) begin
            @(negedge clk_i);
            k++;
        end
    endtask
    // wait for one command and compare it; an unknown it skips the interrupt flag
    task automatic expc(input logic sp, input logic [31:0] v, input logic it, output int k);
        wait_cmd(40, k);
        chk("cmd_valid", cmd_valid_o, 1'b1);
        chk("cmd_is_speed", cmd_is_speed_o, sp);
        chk(sp ? "speed_value" : "target", sp ? speed_value_o : target_position_o, v);
        if (it !== 1'bx)
            chk("interrupt", cmd_interrupt_o, it);
    endtask
    task automatic idle_chk(input string nm);
        wait_cmd(30, n);
        chk("no_cmd", cmd_valid_o, 1'b0);
        chk("busy", busy_o, 1'b0);
        $display("test %s done", nm);
    endtask
    task automatic go(input logic [3:0] s);
        wr(12'h000, {20'h00000, s, 8'h01});
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(12'h004, 32'h0000_0000, "status_reset");
        rd(12'h008, 32'h0000_0000, "target_reset");
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            val[i] = (i == 10) ? 32'h0000_000C : seed;
            seed = lfsr(seed);
            cwv[i] = {seed[31:16], 11'h000, IE[i], PT[2*i +: 2], MD[2*i +: 2]};
            wr(12'h100 + 12'(4 * i), cwv[i]);
            wr(12'h200 + 12'(4 * i), val[i]);
        end
        wr(12'hFFC, seed);
        rd(12'hFFC, 32'h0000_0000, "unmapped");
        rd(12'h120, cwv[8], "cw8");
        fdb_v = lfsr(seed);
        rem_v = lfsr(fdb_v);
        $display("test registers done");
        go(4'h0);
        expc(1'b0, tgt(0, 0, 0), 1'bx, n);
        chk("param", param_select_o, cwv[0][31:16]);
        idle_chk("single");
        go(4'h1);
        expc(1'b0, tgt(1, 0, 0), 1'bx, n);
        expc(1'b0, tgt(2, tgt(1, 0, 0), 0), 1'b0, n);
        chk("hold_gap", n >= 8, 1'b1);
        expc(1'b0, tgt(3, 0, 0), 1'b0, n);
        idle_chk("multi");
        go(4'h4);
        expc(1'b0, tgt(4, 0, 0), 1'bx, n);
        expc(1'b0, tgt(5, tgt(4, 0, 0), rem_v), 1'b1, n);
        chk("intr_gap", n < 8, 1'b1);
        idle_chk("interrupt");
        go(4'h6);
        expc(1'b1, val[6], 1'bx, n);
        expc(1'b0, tgt(7, 0, 0), 1'bx, n);
        chk("chain_gap", n >= 8, 1'b1);
        idle_chk("speed_chain");
        go(4'h8);
        expc(1'b1, val[8], 1'bx, n);
        wait_cmd(30, n);
        chk("no_chain", cmd_valid_o, 1'b0);
        chk("speed_kept", speed_value_o, val[8]);
        wr(12'h000, 32'h0000_0004);
        expc(1'b0, tgt(9, 0, 0), 1'bx, n);
        idle_chk("speed_hold");
        go(4'hA);
        expc(1'b0, tgt(12, 0, 0), 1'bx, n);
        chk("jump_gap", n < 8, 1'b1);
        chk("seg_index", seg_idx, 32'h0000_000C);
        idle_chk("jump");
        go(4'h8);
        expc(1'b1, val[8], 1'bx, n);
        wr(12'h000, 32'h0000_0002);
        idle_chk("stop");
        rd(12'h004, 32'h0002_0800, "status_speed");
        rd(12'h008, val[12], "target_kept");
        rd(12'h00C, val[12], "prev_cmd");
        rd(12'h010, val[8], "speed_reg");
        final_report;
    end
endmodule // tb_top
`default_nettype wire
